// ---- hdl/selftest_pkg.sv ----
/*
 * shared constants for the onboard self-test sequencer: register offsets,
 * command codes, result codes, field positions, reset values and test sizes.
 * assumes: imported whole by every design module of the block.
 */
package selftest_pkg;
    // register offsets on the plain register port
    localparam logic [4:0] OFS_CMD = 5'h00;
    localparam logic [4:0] OFS_RESULT = 5'h04;
    localparam logic [4:0] OFS_INT_EN = 5'h08;
    localparam logic [4:0] OFS_INT_STAT = 5'h0c;
    localparam logic [4:0] OFS_FAULT = 5'h10;
    // command codes written to the command register
    localparam logic [7:0] CMD_RESET = 8'h3f;
    localparam logic [7:0] CMD_DIAG = 8'h0a;
    // diagnostic result codes
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_ROM = 8'h02;
    localparam logic [7:0] RES_RAM = 8'h03;
    localparam logic [7:0] RES_ADDR = 8'h04;
    localparam logic [7:0] RES_LOOP = 8'h05;
    // field positions
    localparam int INT_DONE_BIT = 0;
    localparam int INT_FAIL_BIT = 1;
    localparam int RRF_BIT = 7;
    localparam int FLT_ROM_BIT = 0;
    localparam int FLT_RAM_BIT = 1;
    localparam int FLT_ADDR_BIT = 2;
    localparam int FLT_LOOP_BIT = 3;
    // values after reset
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [3:0] FAULT_RST = 4'h0;
    // test sizes, as last index values, then the expected loopback byte count and last byte
    localparam logic [3:0] ROM_SUM_LAST = 4'hd;
    localparam logic [3:0] RAM_LAST = 4'h7;
    localparam logic [1:0] PAT_LAST = 2'h3;
    localparam logic [3:0] LB_LAST_IDX = 4'h7;
    localparam logic [2:0] ADDR_LAST = 3'h5;
    localparam logic [3:0] LB_RX_EXPECT = 4'h4;
    localparam logic [7:0] LB_LAST_BYTE = 8'h17;
    // program rom image: station address, filler, checksum in the last two bytes
    localparam logic [7:0] ROM_IMAGE [16] = '{8'h02, 8'h00, 8'h00, 8'h12, 8'h34, 8'h56,
        8'ha5, 8'h5a, 8'h0f, 8'hf0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h03, 8'h46};
    // fixed scratchpad patterns
    localparam logic [7:0] RAM_PATTERNS [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    // sequencer steps
    typedef enum logic [3:0] {
        S_IDLE, S_OFFLINE, S_LED_ON, S_ROM, S_ROM_CMP, S_RAM_WR, S_RAM_RD,
        S_ADDR, S_LB_TX, S_LB_WAIT, S_LB_JUDGE, S_REINIT, S_LED_OFF, S_REPORT
    } seq_state_e;
endpackage : selftest_pkg

// ---- hdl/lb_if.sv ----
/*
 * internal loopback path between the sequencer and the address filter.
 * assumes: both ends on ref_clk; one transmit byte per cycle.
 */
`timescale 1ns/1ps
interface lb_if;
    logic tx_valid; // transmit byte present
    logic tx_first; // first byte of a frame
    logic [7:0] tx_data; // transmit byte
    logic [47:0] own_addr; // station address, first byte in the top bits
    logic rx_valid; // accepted payload byte present
    logic [7:0] rx_data; // accepted payload byte
    modport seq (output tx_valid, tx_first, tx_data, own_addr, input rx_valid, rx_data);
    modport filt (input tx_valid, tx_first, tx_data, own_addr, output rx_valid, rx_data);
endinterface : lb_if

// ---- hdl/lb_addr_filter.sv ----
/*
 * receive address recognition for internal loopback: six destination bytes,
 * then payload bytes passed on only for own, multicast or broadcast frames.
 * assumes: frames arrive back to back from the sequencer, first byte flagged.
 */
`timescale 1ns/1ps
module lb_addr_filter
    import selftest_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // loopback path
    lb_if.filt lb
);
    logic [2:0] pos; // destination byte position
    logic own_hit; // destination still equals own address
    logic mcast; // group bit of first destination byte
    logic rx_valid; // registered accept strobe
    logic [7:0] rx_data; // registered accepted byte
    logic [2:0] next_pos;
    logic next_own_hit;
    logic next_mcast;
    logic next_rx_valid;
    logic [7:0] next_rx_data;
    logic [2:0] cur_pos;
    logic cur_own;

    // next values of the recognition state
    always_comb begin
        cur_pos = lb.tx_first ? 3'h0 : pos;
        cur_own = lb.tx_first ? 1'b1 : own_hit;
        next_pos = pos;
        next_own_hit = own_hit;
        next_mcast = mcast;
        next_rx_valid = 1'b0;
        next_rx_data = rx_data;
        if (lb.tx_valid) begin
            if (cur_pos <= ADDR_LAST) begin
                // compare destination byte against the station address
                next_own_hit = cur_own &&
                    (lb.tx_data == lb.own_addr[8 * (3'h5 - cur_pos) +: 8]);
                if (cur_pos == 3'h0) begin
                    next_mcast = lb.tx_data[0];
                end
                next_pos = cur_pos + 3'h1;
            end else if (own_hit || mcast) begin
                // only frames for this board reach the receive side [R17]
                next_rx_valid = 1'b1;
                next_rx_data = lb.tx_data;
            end
        end
    end

    // register recognition state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pos <= 3'h0;
            own_hit <= 1'b0;
            mcast <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            pos <= next_pos;
            own_hit <= next_own_hit;
            mcast <= next_mcast;
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
        end
    end

    assign lb.rx_valid = rx_valid;
    assign lb.rx_data = rx_data;
endmodule : lb_addr_filter

// ---- hdl/onboard_selftest_sequencer.sv ----
/*
 * onboard self-test sequencer: rom checksum, scratchpad pattern test,
 * station address check and two-frame internal loopback, with result
 * reporting, pass/fail indicator and result-ready interrupt.
 * assumes: register port inputs synchronous to ref_clk, one strobe per cycle.
 */
// The plain strobed port and the placing of the registers were decided locally.
// Contract
// [R01] hard reset, reset or diagnostics command start tests
// [R02] rom checksum compared with last two bytes
// [R03] patterns, station address and loopback also tested
// [R04] failure reports code, indicator stays lit
// [R05] indicator dark normally, blinks on success
// [R06] diagnostics: go offline, then light indicator
// [R07] rom mismatch sets rom code, reports
// [R08] four patterns checked; mismatch sets ram code
// [R09] bad station address sets address code
// [R10] two loopback frames decide success or loop code
// [R11] after passing, reinitialise all state
// [R12] indicator off only for success code
// [R13] result to status, result ready flag set
// [R14] failed run leaves board uninitialised
// [R15] host resets board after failed diagnostics
// [R16] host reads status as result code
// [R17] loopback accepts own, multicast, broadcast only
// [R18] tests run strictly one after another
// [R19] result held until read or new run
`timescale 1ns/1ps
module onboard_selftest_sequencer
    import selftest_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // board status
    output logic irq,
    output logic pass_fail_led,
    output logic online,
    output logic state_clear,
    output logic busy
);
    seq_state_e state; // current test step
    logic [3:0] idx; // byte index within a step
    logic [1:0] pat; // pattern number
    logic frame; // loopback frame number
    logic [15:0] sum; // running rom checksum
    logic [7:0] code; // working status value
    logic [7:0] result; // status register
    logic pending; // run owed since hard reset
    logic [3:0] rx_cnt; // loopback bytes received
    logic [7:0] rx_last; // last loopback byte received
    logic led; // indicator register
    logic on_line; // board initialised and online
    logic clr; // reinitialise pulse register
    seq_state_e next_state;
    logic [3:0] next_idx, next_rx_cnt;
    logic [1:0] next_pat;
    logic next_frame, next_pending, next_led, next_on_line, next_clr;
    logic [15:0] next_sum;
    logic [7:0] next_code, next_result, next_rx_last;
    logic [7:0] ram [8]; // scratchpad ram
    logic ram_we; // scratchpad write enable
    logic [7:0] ram_wdata; // scratchpad write byte
    logic [1:0] mask; // interrupt mask
    logic [1:0] int_stat; // sticky interrupt status
    logic rrf; // result_ready_flag
    logic [3:0] fault; // fault injection controls
    logic [7:0] rdata; // registered read data
    logic [1:0] next_mask, next_int_stat;
    logic next_rrf;
    logic [3:0] next_fault;
    logic [7:0] next_rdata;
    logic start_cmd; // valid command written
    logic start; // run begins this cycle
    logic done_evt; // result reported this cycle
    logic [7:0] rom_rd; // rom byte seen by the checksum
    logic [7:0] tx_byte; // loopback byte to send
    lb_if lb ();
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // loopback receive side
    lb_addr_filter lb_addr_filter_i (.ref_clk(ref_clk), .rst_b(rst_b), .lb(lb));

    // command decode and start condition
    always_comb begin
        start_cmd = reg_wr && (reg_addr == OFS_CMD) &&
            ((reg_wdata == CMD_RESET) || (reg_wdata == CMD_DIAG));
        start = (state == S_IDLE) && (pending || start_cmd); // [R01]
        done_evt = (state == S_REPORT);
    end

    // test data sources, with fault injection
    always_comb begin
        rom_rd = ROM_IMAGE[idx] ^ {7'h00, (idx == 4'h0) && fault[FLT_ROM_BIT]};
        lb.own_addr = {ROM_IMAGE[0] ^ {7'h00, fault[FLT_ADDR_BIT]}, ROM_IMAGE[1],
            ROM_IMAGE[2], ROM_IMAGE[3], ROM_IMAGE[4], ROM_IMAGE[5]};
        if (idx > 4'h5) begin
            tx_byte = {3'h0, frame, idx};
        end else if (frame) begin
            tx_byte = 8'hff; // broadcast frame
        end else begin
            tx_byte = lb.own_addr[8 * (3'h5 - idx[2:0]) +: 8] ^
                {(idx == 4'h0) && fault[FLT_LOOP_BIT], 7'h00};
        end
        lb.tx_valid = (state == S_LB_TX);
        lb.tx_first = (state == S_LB_TX) && (idx == 4'h0);
        lb.tx_data = tx_byte;
    end

    // next values of the sequencer
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_pat = pat;
        next_frame = frame;
        next_sum = sum;
        next_code = code;
        next_result = result;
        next_pending = pending;
        next_rx_cnt = rx_cnt;
        next_rx_last = rx_last;
        next_led = led;
        next_on_line = on_line;
        next_clr = 1'b0;
        ram_we = 1'b0;
        ram_wdata = RAM_PATTERNS[pat] ^ {7'h00, fault[FLT_RAM_BIT]};
        if (lb.rx_valid) begin
            next_rx_cnt = rx_cnt + 4'h1;
            next_rx_last = lb.rx_data;
        end
        // each step leaves only after judging its test [R18]
        case (state)
            S_IDLE: begin
                if (start) begin
                    next_pending = 1'b0;
                    next_state = S_OFFLINE;
                end
            end
            S_OFFLINE: begin
                next_on_line = 1'b0; // [R06]
                next_state = S_LED_ON;
            end
            S_LED_ON: begin
                next_led = 1'b1; // [R05] [R06]
                next_idx = 4'h0;
                next_sum = 16'h0000;
                next_state = S_ROM;
            end
            S_ROM: begin
                next_sum = sum + {8'h00, rom_rd}; // [R02]
                next_idx = idx + 4'h1;
                if (idx == ROM_SUM_LAST) next_state = S_ROM_CMP;
            end
            S_ROM_CMP: begin
                next_idx = 4'h0;
                next_pat = 2'h0;
                if (sum != {ROM_IMAGE[14], ROM_IMAGE[15]}) begin
                    next_code = RES_ROM; // [R07]
                    next_state = S_REPORT;
                end else begin
                    next_state = S_RAM_WR;
                end
            end
            S_RAM_WR: begin
                ram_we = 1'b1; // [R03]
                next_idx = idx + 4'h1;
                if (idx == RAM_LAST) begin
                    next_idx = 4'h0;
                    next_state = S_RAM_RD;
                end
            end
            S_RAM_RD: begin
                next_idx = idx + 4'h1;
                if (ram[idx[2:0]] != RAM_PATTERNS[pat]) begin
                    next_code = RES_RAM; // [R08]
                    next_state = S_REPORT;
                end else if (idx == RAM_LAST) begin
                    next_idx = 4'h0;
                    next_pat = pat + 2'h1;
                    next_state = (pat == PAT_LAST) ? S_ADDR : S_RAM_WR;
                end
            end
            S_ADDR: begin
                // unicast and not all zero [R03]
                if (lb.own_addr[40] || lb.own_addr == 48'h0) begin
                    next_code = RES_ADDR; // [R09]
                    next_state = S_REPORT;
                end else begin
                    next_idx = 4'h0;
                    next_frame = 1'b0;
                    next_rx_cnt = 4'h0;
                    next_rx_last = 8'h00;
                    next_state = S_LB_TX;
                end
            end
            S_LB_TX: begin
                next_idx = idx + 4'h1;
                if (idx == LB_LAST_IDX) begin
                    next_idx = 4'h0;
                    next_frame = 1'b1;
                    next_state = frame ? S_LB_WAIT : S_LB_TX;
                end
            end
            S_LB_WAIT: next_state = S_LB_JUDGE;
            S_LB_JUDGE: begin
                if (rx_cnt == LB_RX_EXPECT && rx_last == LB_LAST_BYTE) begin
                    next_code = RES_OK; // [R10]
                    next_state = S_REINIT;
                end else begin
                    next_code = RES_LOOP; // [R10]
                    next_state = S_REPORT;
                end
            end
            S_REINIT: begin
                next_clr = 1'b1; // only a passing run gets here [R11] [R14]
                next_on_line = 1'b1;
                next_state = S_LED_OFF;
            end
            S_LED_OFF: begin
                if (code == RES_OK) next_led = 1'b0; // [R12]
                next_state = S_REPORT;
            end
            S_REPORT: begin
                next_result = code; // failures arrive with the indicator lit [R04] [R13] [R19]
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    // register the sequencer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            idx <= 4'h0;
            pat <= 2'h0;
            frame <= 1'b0;
            sum <= 16'h0000;
            code <= RES_OK;
            result <= RESULT_RST;
            pending <= 1'b1; // hard reset owes a run [R01]
            rx_cnt <= 4'h0;
            rx_last <= 8'h00;
            led <= 1'b0;
            on_line <= 1'b0;
            clr <= 1'b0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            pat <= next_pat;
            frame <= next_frame;
            sum <= next_sum;
            code <= next_code;
            result <= next_result;
            pending <= next_pending;
            rx_cnt <= next_rx_cnt;
            rx_last <= next_rx_last;
            led <= next_led;
            on_line <= next_on_line;
            clr <= next_clr;
        end
    end

    // scratchpad write port, no reset on the array
    always_ff @(posedge ref_clk) begin
        if (ram_we) ram[idx[2:0]] <= ram_wdata;
    end

    // next values of the register file
    always_comb begin
        next_mask = mask;
        next_fault = fault;
        next_int_stat = int_stat;
        next_rrf = rrf;
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFS_RESULT: begin
                    next_rdata = result;
                    next_rrf = 1'b0; // host has taken the result
                end
                OFS_INT_EN: next_rdata = {rrf, 5'h00, mask};
                OFS_INT_STAT: begin
                    next_rdata = {6'h00, int_stat};
                    next_int_stat = 2'h0; // read clears
                end
                OFS_FAULT: next_rdata = {4'h0, fault};
                default: next_rdata = 8'h00;
            endcase
        end
        if (reg_wr && reg_addr == OFS_INT_EN) next_mask = reg_wdata[1:0];
        if (reg_wr && reg_addr == OFS_FAULT) next_fault = reg_wdata[3:0];
        if (start) next_rrf = 1'b0; // new run withdraws the old result
        // events win over a clearing read
        if (done_evt) begin
            next_rrf = 1'b1; // [R13]
            next_int_stat[INT_DONE_BIT] = 1'b1;
            next_int_stat[INT_FAIL_BIT] = int_stat[INT_FAIL_BIT] | (code != RES_OK);
        end
    end

    // register the register file
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask <= MASK_RST;
            int_stat <= 2'h0;
            rrf <= 1'b0;
            fault <= FAULT_RST;
            rdata <= 8'h00;
        end else begin
            mask <= next_mask;
            int_stat <= next_int_stat;
            rrf <= next_rrf;
            fault <= next_fault;
            rdata <= next_rdata;
        end
    end

    // outputs
    assign reg_rdata = rdata;
    assign irq = |(int_stat & mask);
    assign pass_fail_led = led;
    assign online = on_line;
    assign state_clear = clr;
    assign busy = (state != S_IDLE);

    a_cmd_starts_run: assert property ( // [R01]
        (state == S_IDLE && start_cmd) |=> (state == S_OFFLINE) ##1 !on_line ##1 led)
        else $error("command did not start the test run");
    a_offline_first: assert property ( // [R06]
        $rose(led) |-> !on_line && $past(state) == S_LED_ON)
        else $error("indicator lit while still online");
    a_rom_fail_jump: assert property ( // [R07]
        (state == S_ROM_CMP && sum != {ROM_IMAGE[14], ROM_IMAGE[15]})
        |=> state == S_REPORT && code == RES_ROM ##1 result == RES_ROM)
        else $error("rom mismatch not reported");
    a_ram_fail_code: assert property ( // [R08]
        (state == S_RAM_RD && ram[idx[2:0]] != RAM_PATTERNS[pat])
        |=> state == S_REPORT && code == RES_RAM)
        else $error("ram mismatch not reported");
    a_addr_fail_code: assert property ( // [R09]
        (state == S_ADDR && lb.own_addr[40]) |=> state == S_REPORT && code == RES_ADDR)
        else $error("bad station address not reported");
    a_led_off_pass: assert property ( // [R12]
        $fell(led) |-> code == RES_OK ##1 result == RES_OK)
        else $error("indicator went dark without success");
    a_fail_keeps_led: assert property ( // [R04] [R14]
        (state == S_REPORT && code != RES_OK) |-> led && !on_line ##1 !clr && led)
        else $error("failed run cleared indicator or state");
    a_report_flag: assert property ( // [R13]
        (state == S_REPORT) |=> rrf && result == $past(code) && int_stat[INT_DONE_BIT])
        else $error("result or ready flag not set on report");
    a_result_hold: assert property ( // [R19]
        (state != S_REPORT) |=> $stable(result))
        else $error("result changed outside reporting");
    a_reinit_pass: assert property ( // [R11]
        (state == S_REINIT) |-> code == RES_OK ##1 clr && on_line)
        else $error("reinitialise without a passing run");
endmodule : onboard_selftest_sequencer

// ---- tb/host_model.sv ----
/* host processor model: single-cycle register writes and reads.
 * assumes: shares ref_clk with the sequencer; one access at a time. */
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic [4:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // idle bus from time zero
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write cycle; released data shows the inverse
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // one read cycle; data taken in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata; // status taken as result code
    endtask : rd
endmodule : host_model

// ---- tb/onboard_selftest_sequencer_tb.sv ----
/* testbench for the self-test sequencer: power-up, failing and passing runs.
 * assumes: host_model drives the register port on ref_clk. */
`timescale 1ns/1ps
module onboard_selftest_sequencer_tb
    import selftest_pkg::*;
;
    logic ref_clk; // 125 MHz clock
    logic rst_b; // active low reset
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic irq;
    logic pass_fail_led;
    logic online;
    logic state_clear;
    logic busy;
    int fail_count = 0; // mismatches
    int samples_checked = 0; // comparisons
    int pulses = 0; // reinit pulses seen
    onboard_selftest_sequencer onboard_selftest_sequencer_i (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .pass_fail_led(pass_fail_led), .online(online),
        .state_clear(state_clear), .busy(busy));
    host_model host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // clock
    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;
    // count reinit pulses
    always @(posedge ref_clk) begin
        if (state_clear === 1'b1) pulses++;
    end
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // bounded wait for the run to end
    task automatic wait_idle();
        int n;
        n = 0;
        #1; // step off the edge so busy shows the registered state
        while (busy !== 1'b0 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            $display("MISMATCH t=%0t busy=%h exp=%h", $time, busy, 1'b0);
            conclude();
        end
    endtask : wait_idle
    // one commanded run and its report
    task automatic do_run(input logic [7:0] cmd, input logic [7:0] flt, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        int p0;
        ok = (exp == RES_OK);
        p0 = pulses;
        host_model_i.wr(OFS_FAULT, flt);
        host_model_i.wr(OFS_INT_EN, 8'h03);
        host_model_i.wr(OFS_CMD, cmd);
        repeat (4) @(posedge ref_clk);
        #1;
        chk({6'h0, online, pass_fail_led}, 8'h01);
        wait_idle();
        chk({7'h0, pass_fail_led}, {7'h0, !ok});
        chk({7'h0, online}, {7'h0, ok});
        chk(8'(pulses - p0), {7'h0, ok});
        chk({7'h0, irq}, 8'h01);
        host_model_i.rd(OFS_INT_EN, d);
        chk(d, 8'h83);
        host_model_i.rd(OFS_RESULT, d);
        chk(d, exp);
        host_model_i.rd(OFS_RESULT, d);
        chk(d, exp);
        host_model_i.rd(OFS_INT_EN, d);
        chk(d, 8'h03);
        host_model_i.rd(OFS_INT_STAT, d);
        chk(d, {6'h0, !ok, 1'b1});
        chk({7'h0, irq}, 8'h00);
    endtask : do_run
    // run pending after hard reset passes
    task automatic t_powerup();
        logic [7:0] d;
        wait_idle();
        chk({6'h0, online, pass_fail_led}, 8'h02);
        chk({7'h0, irq}, 8'h00);
        host_model_i.rd(OFS_RESULT, d);
        chk(d, RES_OK);
        host_model_i.wr(OFS_INT_EN, 8'h03);
        #1;
        chk({7'h0, irq}, 8'h01);
        host_model_i.rd(OFS_INT_STAT, d);
        chk(d, 8'h01);
        host_model_i.rd(5'h1f, d);
        chk(d, 8'h00);
        $display("test powerup done");
    endtask : t_powerup
    // each fault kind ends its run with its own code
    task automatic t_faults();
        logic [7:0] f [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
        logic [7:0] r [4] = '{RES_ROM, RES_RAM, RES_ADDR, RES_LOOP};
        for (int i = 0; i < 4; i++) begin
            do_run(i[0] ? CMD_RESET : CMD_DIAG, f[i], r[i]);
        end
        $display("test faults done");
    endtask : t_faults
    // host recovers a failed board with a reset command
    task automatic t_recover();
        do_run(CMD_RESET, 8'h00, RES_OK);
        do_run(CMD_DIAG, 8'h00, RES_OK);
        $display("test recover done");
    endtask : t_recover
    // main sequence
    initial begin
        rst_b = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_powerup();
        t_faults();
        t_recover();
        conclude();
    end
endmodule : onboard_selftest_sequencer_tb
